// File: irq_pins_pkg.sv
// package: constants and types for the external interrupt pin and acknowledge logic
package irq_pins_pkg;

	// apb register byte offsets
	localparam logic [11:0] polarity_offset = 12'h000;
	localparam logic [11:0] mask_offset     = 12'h004;
	localparam logic [11:0] pending_offset  = 12'h008;
	localparam logic [11:0] service_offset  = 12'h00C;

	// reset values
	localparam logic [3:0]  polarity_reset  = 4'h0;
	localparam logic [15:0] mask_reset      = 16'h0000;

	// interrupt numbering
	localparam int          irq_count       = 16;
	localparam int          fixed_count     = 4;
	localparam logic [3:0]  nmi_number      = 4'h1;
	localparam logic [3:0]  ext_first       = 4'h4;
	localparam int          ext_count       = 4;

	// fixed interrupts that may never be masked
	localparam logic [15:0] unmaskable      = 16'h000F;

	// acknowledge strobe length in clock cycles
	localparam logic [1:0]  ack_cycles      = 2'h1;

	// serviced interrupt report carried to the pins
	typedef struct packed {
		logic       ack;
		logic [3:0] number;
	} ack_report_t;

	typedef enum logic [1:0] {
		st_idle,
		st_ack,
		st_hold
	} svc_state_t;

endpackage

// File: irq_pins.sv
// module: edge-detected external interrupts, nmi, priority arbiter, acknowledge and number
//
// Contract
// - four external inputs edge-detected, per-bit polarity
// - acknowledge pulses for every serviced interrupt
// - four-bit bus names serviced interrupt number
// - number valid whenever acknowledge is high
// - number equals service table position
// - sixteen priorities, zero highest, fifteen lowest
// - zero to three unmaskable; four up maskable
module irq_pins (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// interrupt sources
	input  wire logic        nmi_i,
	input  wire logic        ext_irq_in_a_i,
	input  wire logic        ext_irq_in_b_i,
	input  wire logic        ext_irq_in_c_i,
	input  wire logic        ext_irq_in_d_i,
	input  wire logic [15:0] int_src_i,
	// core side: ready to take an interrupt
	input  wire logic        core_ready_i,
	// acknowledge pins
	output logic             irq_ack_strobe_o,
	output logic [3:0]       serviced_irq_number_o
);

	logic [3:0]  ext_pins;
	logic [3:0]  ext_sync1_reg;
	logic [3:0]  ext_sync2_reg;
	logic [3:0]  ext_last_reg;
	logic [3:0]  ext_edge;
	logic        nmi_sync1_reg;
	logic        nmi_sync2_reg;
	logic        nmi_last_reg;
	logic        nmi_edge;
	logic [3:0]  ext_irq_edge_polarity_reg;
	logic [15:0] mask_reg;
	logic [15:0] pending_reg;
	logic [15:0] pending_next;
	logic [15:0] eligible;
	logic        grant_valid;
	logic [3:0]  grant_num;
	logic        take;
	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;
	irq_pins_pkg::svc_state_t state_reg;
	irq_pins_pkg::ack_report_t report_reg;
	logic [3:0]  last_served_reg;

	assign ext_pins = {ext_irq_in_d_i, ext_irq_in_c_i, ext_irq_in_b_i, ext_irq_in_a_i};

	// two-flop synchronisers; only the second stage is examined
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ext_sync1_reg <= 4'h0;
			ext_sync2_reg <= 4'h0;
			nmi_sync1_reg <= 1'b0;
			nmi_sync2_reg <= 1'b0;
		end else begin
			ext_sync1_reg <= ext_pins;
			ext_sync2_reg <= ext_sync1_reg;
			nmi_sync1_reg <= nmi_i;
			nmi_sync2_reg <= nmi_sync1_reg;
		end
	end

	// previous raw level; a polarity write alone then makes no edge
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ext_last_reg <= 4'h0;
			nmi_last_reg <= 1'b0;
		end else begin
			ext_last_reg <= ext_sync2_reg;
			nmi_last_reg <= nmi_sync2_reg;
		end
	end

	// polarity bit 1 selects the falling edge
	assign ext_edge = (ext_sync2_reg ^ ext_irq_edge_polarity_reg) &
		~(ext_last_reg ^ ext_irq_edge_polarity_reg);
	assign nmi_edge = nmi_sync2_reg & ~nmi_last_reg;

	// apb decode, zero wait states
	assign addr_ok = (paddr_i == irq_pins_pkg::polarity_offset) ||
		(paddr_i == irq_pins_pkg::mask_offset) ||
		(paddr_i == irq_pins_pkg::pending_offset) ||
		(paddr_i == irq_pins_pkg::service_offset);
	assign wr_en = psel_i && penable_i && pwrite_i;
	assign rd_en = psel_i && !penable_i && !pwrite_i;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ext_irq_edge_polarity_reg <= irq_pins_pkg::polarity_reset;
			mask_reg                  <= irq_pins_pkg::mask_reset;
		end else if (wr_en) begin
			if (paddr_i == irq_pins_pkg::polarity_offset) begin
				ext_irq_edge_polarity_reg <= pwdata_i[3:0];
			end else if (paddr_i == irq_pins_pkg::mask_offset) begin
				mask_reg <= pwdata_i[15:0];
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_o  <= 32'h0000_0000;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && !addr_ok;
			if (rd_en) begin
				if (paddr_i == irq_pins_pkg::polarity_offset) begin
					prdata_o <= {28'h000_0000, ext_irq_edge_polarity_reg};
				end else if (paddr_i == irq_pins_pkg::mask_offset) begin
					prdata_o <= {16'h0000, mask_reg};
				end else if (paddr_i == irq_pins_pkg::pending_offset) begin
					prdata_o <= {16'h0000, pending_reg};
				end else if (paddr_i == irq_pins_pkg::service_offset) begin
					prdata_o <= {27'h000_0000, state_reg != irq_pins_pkg::st_idle,
						last_served_reg};
				end else begin
					prdata_o <= 32'h0000_0000;
				end
			end
		end
	end

	// fixed interrupts ignore the mask
	assign eligible = pending_reg & (mask_reg | irq_pins_pkg::unmaskable);

	// lowest number wins
	always_comb begin
		grant_valid = 1'b0;
		grant_num   = 4'h0;
		for (int i = irq_pins_pkg::irq_count - 1; i >= 0; i--) begin
			if (eligible[i]) begin
				grant_valid = 1'b1;
				grant_num   = 4'(i);
			end
		end
	end

	assign take = grant_valid && core_ready_i && (state_reg == irq_pins_pkg::st_idle);

	// pending flags: a new event wins over the clear by service
	always_comb begin
		pending_next = pending_reg;
		if (take) begin
			pending_next[grant_num] = 1'b0;
		end
		for (int k = 0; k < irq_pins_pkg::irq_count; k++) begin
			if (k != int'(irq_pins_pkg::nmi_number)) begin
				pending_next[k] = pending_next[k] | int_src_i[k];
			end
		end
		pending_next[irq_pins_pkg::nmi_number] = pending_next[irq_pins_pkg::nmi_number] |
			nmi_edge;
		for (int k = 0; k < irq_pins_pkg::ext_count; k++) begin
			pending_next[int'(irq_pins_pkg::ext_first) + k] =
				pending_next[int'(irq_pins_pkg::ext_first) + k] | ext_edge[k];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pending_reg <= 16'h0000;
		end else begin
			pending_reg <= pending_next;
		end
	end

	// service sequencer: one acknowledge cycle, then one idle gap
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg       <= irq_pins_pkg::st_idle;
			report_reg      <= '0;
			last_served_reg <= 4'h0;
		end else begin
			case (state_reg)
				irq_pins_pkg::st_idle: begin
					report_reg.ack <= 1'b0;
					if (take) begin
						state_reg         <= irq_pins_pkg::st_ack;
						report_reg.ack    <= 1'b1;
						report_reg.number <= grant_num;
						last_served_reg   <= grant_num;
					end
				end
				irq_pins_pkg::st_ack: begin
					report_reg.ack <= 1'b0;
					state_reg      <= irq_pins_pkg::st_hold;
				end
				default: begin
					report_reg.ack <= 1'b0;
					state_reg      <= irq_pins_pkg::st_idle;
				end
			endcase
		end
	end

	assign irq_ack_strobe_o      = report_reg.ack;
	assign serviced_irq_number_o = report_reg.number;

	chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_ack_strobe_o |=> !irq_ack_strobe_o)
		else $error("acknowledge longer than one cycle");

	chk_ack_follows_take: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> irq_ack_strobe_o)
		else $error("serviced interrupt not acknowledged");

	chk_number_matches: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> serviced_irq_number_o == $past(grant_num))
		else $error("number differs from granted interrupt");

	chk_number_stable: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_ack_strobe_o |=> $stable(serviced_irq_number_o))
		else $error("number changed right after acknowledge");

	chk_priority_order: assert property (@(posedge clk_i) disable iff (rst_i)
		take |-> ((eligible & ((16'h0001 << grant_num) - 16'h0001)) == 16'h0000))
		else $error("higher priority interrupt skipped");

	chk_fixed_unmasked: assert property (@(posedge clk_i) disable iff (rst_i)
		((pending_reg & irq_pins_pkg::unmaskable) != 16'h0000) && core_ready_i &&
		(state_reg == irq_pins_pkg::st_idle) |-> take)
		else $error("fixed interrupt not served");

	sequence nmi_rise_s;
		!nmi_sync2_reg ##1 nmi_sync2_reg;
	endsequence

	chk_nmi_pending: assert property (@(posedge clk_i) disable iff (rst_i)
		nmi_rise_s |=> pending_reg[1])
		else $error("nmi edge not latched");

	chk_ext_edge_sets: assert property (@(posedge clk_i) disable iff (rst_i)
		ext_edge[0] |=> pending_reg[4])
		else $error("external edge not latched");

	chk_mask_obeyed: assert property (@(posedge clk_i) disable iff (rst_i)
		take |-> (mask_reg[grant_num] || irq_pins_pkg::unmaskable[grant_num]))
		else $error("masked interrupt served");

	chk_ack_from_take: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_ack_strobe_o |-> $past(take))
		else $error("acknowledge without a serviced interrupt");

	sequence svc_steps_s;
		irq_ack_strobe_o ##1 (state_reg == irq_pins_pkg::st_hold) ##1
			(state_reg == irq_pins_pkg::st_idle);
	endsequence

	chk_service_steps: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> svc_steps_s)
		else $error("service sequence broken");

	chk_no_take_in_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_ack_strobe_o |-> !take ##1 !take)
		else $error("new service during acknowledge gap");

	chk_number_held: assert property (@(posedge clk_i) disable iff (rst_i)
		!take |=> $stable(serviced_irq_number_o))
		else $error("number changed without a service");

	sequence ext_b_active_s;
		(ext_sync2_reg[1] == ext_irq_edge_polarity_reg[1]) ##1
			((ext_sync2_reg[1] != ext_irq_edge_polarity_reg[1]) &&
			$stable(ext_irq_edge_polarity_reg[1]));
	endsequence

	chk_ext_b_edge: assert property (@(posedge clk_i) disable iff (rst_i)
		ext_b_active_s |=> pending_reg[int'(irq_pins_pkg::ext_first) + 1])
		else $error("active edge of pin b not latched");

	chk_ext_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		(!pending_reg[4] && !ext_edge[0] && !int_src_i[4]) |=> !pending_reg[4])
		else $error("pin flag set without an edge");

	chk_nmi_single: assert property (@(posedge clk_i) disable iff (rst_i)
		nmi_edge |=> !nmi_edge)
		else $error("nmi edge longer than one cycle");

	chk_pol_write: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_en && (paddr_i == irq_pins_pkg::polarity_offset)) |=>
		(ext_irq_edge_polarity_reg == $past(pwdata_i[3:0])))
		else $error("polarity write lost");

	chk_apb_ready: assert property (@(posedge clk_i) disable iff (rst_i)
		(psel_i && !penable_i) |=> pready_o)
		else $error("access phase without ready");

	chk_apb_error: assert property (@(posedge clk_i) disable iff (rst_i)
		(psel_i && !penable_i && !addr_ok) |=> pslverr_o)
		else $error("unmapped access without error");

endmodule

// File: irq_src_model.sv
// partner model: external interrupt sources driving the nmi and edge pins
module irq_src_model (
	// clock
	input  wire logic       clk_i,
	// interrupt pins
	output logic      [3:0] ext_o,
	output logic            nmi_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ext_o = 4'h0;
		nmi_o = 1'b0;
	end
	// move the idle level of the pins; a polarity write must come first
	task automatic set_idle(input logic [3:0] v);
		@(posedge clk_i);
		ext_o <= v;
		repeat (4) @(posedge clk_i);
	endtask
	// leave idle and return: held 4 cycles so the synchroniser sees it
	task automatic pulse(input logic [3:0] m, input logic nmi);
		@(posedge clk_i);
		ext_o <= ext_o ^ m;
		nmi_o <= nmi;
		repeat (4) @(posedge clk_i);
		ext_o <= ext_o ^ m;
		nmi_o <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
endmodule

// File: tb_ext_irq_pins_and_ack.sv
// testbench: apb setup, pin edges and acknowledge number checks
module tb_ext_irq_pins_and_ack;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        err_rd;
	logic        core_ready = 1'b1;
	logic [15:0] int_src = 16'h0000;
	logic [3:0]  ext;
	logic        nmi;
	logic        ack;
	logic        ack_prev = 1'b0;
	logic [3:0]  num;
	logic [3:0]  seen_q[$];
	int          err_total = 0;
	int          checks = 0;

	initial forever #5 clk_i = ~clk_i;

	irq_src_model src (.clk_i(clk_i), .ext_o(ext), .nmi_o(nmi));

	irq_pins dut (
		.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .nmi_i(nmi), .ext_irq_in_a_i(ext[0]),
		.ext_irq_in_b_i(ext[1]), .ext_irq_in_c_i(ext[2]), .ext_irq_in_d_i(ext[3]),
		.int_src_i(int_src), .core_ready_i(core_ready), .irq_ack_strobe_o(ack),
		.serviced_irq_number_o(num));

	// number is taken on each rising edge of the acknowledge strobe
	always @(posedge clk_i) begin
		ack_prev <= ack;
		if (ack === 1'b1 && ack_prev !== 1'b1) seen_q.push_back(num);
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %0s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err_rd = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			cmp(0, 1, "apb timeout");
			finish_test();
		end
	endtask

	task automatic expect_ack(input logic [3:0] exp);
		int n;
		n = 0;
		while (seen_q.size() == 0 && n < 200) begin
			@(posedge clk_i);
			n++;
		end
		if (seen_q.size() == 0) begin
			cmp(0, 1, "no acknowledge");
			finish_test();
		end
		cmp(seen_q.pop_front(), exp, "irq number");
	endtask

	task automatic expect_none();
		repeat (30) @(posedge clk_i);
		cmp(seen_q.size(), 0, "stray acknowledge");
	endtask

	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		apb(1'b0, irq_pins_pkg::polarity_offset, 32'h0000_0000);
		cmp(rd[3:0], irq_pins_pkg::polarity_reset, "polarity reset");
		cmp(err_rd, 1'b0, "mapped read error");
		apb(1'b0, irq_pins_pkg::mask_offset, 32'h0000_0000);
		cmp(rd[15:0], irq_pins_pkg::mask_reset, "mask reset");
		$display("test reset values done");
		src.pulse(4'h0, 1'b1);
		expect_ack(irq_pins_pkg::nmi_number);
		expect_none();
		src.pulse(4'h1, 1'b0);
		expect_none();
		apb(1'b0, irq_pins_pkg::pending_offset, 32'h0000_0000);
		cmp(rd, 32'h0000_0010, "masked flag held");
		apb(1'b1, irq_pins_pkg::mask_offset, 32'h0000_00F0);
		expect_ack(4'h4);
		$display("test nmi and masked pin done");
		src.pulse(4'h9, 1'b0);
		expect_ack(4'h4);
		expect_ack(4'h7);
		$display("test priority done");
		apb(1'b1, irq_pins_pkg::polarity_offset, 32'h0000_0002);
		apb(1'b0, irq_pins_pkg::polarity_offset, 32'h0000_0000);
		cmp(rd[3:0], 4'h2, "polarity readback");
		src.set_idle(4'h2);
		expect_none();
		src.pulse(4'h2, 1'b0);
		expect_ack(4'h5);
		apb(1'b0, irq_pins_pkg::service_offset, 32'h0000_0000);
		cmp(rd, 32'h0000_0005, "last served number");
		$display("test polarity done");
		apb(1'b1, irq_pins_pkg::mask_offset, 32'h0000_20F0);
		@(posedge clk_i);
		core_ready <= 1'b0;
		int_src <= 16'h2004;
		@(posedge clk_i);
		int_src <= 16'h0000;
		expect_none();
		core_ready <= 1'b1;
		expect_ack(4'h2);
		expect_ack(4'hD);
		$display("test internal sources done");
		apb(1'b0, 12'h010, 32'h0000_0000);
		cmp(rd, 32'h0000_0000, "unmapped read data");
		cmp(err_rd, 1'b1, "unmapped read error");
		$display("test unmapped read done");
		finish_test();
	end
endmodule
